// [core/int_vec_ctrl.sv]
// interrupt priority arbiter, vector supply and pending status flags
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ns
module int_vec_ctrl
    import int_vec_pkg::*;
(
    // clock, reset, enable
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    // peripheral request flags and local enables
    input  wire logic              reset_request,
    input  wire logic              ext_pin_request_flag,
    input  wire logic              ext_pin_request_mask,
    input  wire logic              timer_chan_zero_flag,
    input  wire logic              timer_chan_zero_enable,
    input  wire logic              timer_chan_one_flag,
    input  wire logic              timer_chan_one_enable,
    input  wire logic              timer_overflow_flag,
    input  wire logic              timer_overflow_enable,
    input  wire logic              keyboard_request_flag,
    input  wire logic              keyboard_request_mask,
    input  wire logic              conversion_done_flag,
    input  wire logic              converter_request_enable,
    // processor core side
    input  wire logic              instr_end,
    input  wire logic              software_interrupt_instruction,
    input  wire logic              global_mask,
    input  wire logic [15:0]       core_pc,
    output logic                   any_pending,
    output logic                   take_valid,
    output src_t                   take_src,
    output logic [15:0]            vector_addr,
    output logic [15:0]            stacked_pc,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [DATA_W-1:0]      reg_rdata,
    // interrupt to system
    output logic                   irq
);

    // vector lookup per source
    function automatic logic [15:0] vec_of(input src_t s);
        case (s)
            SRC_RESET:     vec_of = VEC_RESET;
            SRC_SOFT:      vec_of = VEC_SOFT;
            SRC_EXT_PIN:   vec_of = VEC_EXT_PIN;
            SRC_CHAN_ZERO: vec_of = VEC_CHAN_ZERO;
            SRC_CHAN_ONE:  vec_of = VEC_CHAN_ONE;
            SRC_OVERFLOW:  vec_of = VEC_OVERFLOW;
            SRC_KEYBOARD:  vec_of = VEC_KEYBOARD;
            SRC_CONVERTER: vec_of = VEC_CONVERTER;
            default:       vec_of = RST_WORD;
        endcase
    endfunction

    // module-level requests, before the global mask
    wire logic req_ext_pin;
    wire logic req_chan_zero;
    wire logic req_chan_one;
    wire logic req_overflow;
    wire logic req_keyboard;
    wire logic req_converter;
    assign req_ext_pin   = ext_pin_request_flag & ~ext_pin_request_mask;
    assign req_chan_zero = timer_chan_zero_flag & timer_chan_zero_enable;
    assign req_chan_one  = timer_chan_one_flag & timer_chan_one_enable;
    assign req_overflow  = timer_overflow_flag & timer_overflow_enable;
    assign req_keyboard  = keyboard_request_flag & ~keyboard_request_mask;
    assign req_converter = conversion_done_flag & converter_request_enable;

    // global mask gates maskable sources only
    wire logic maskable_open;
    wire logic any_maskable;
    assign maskable_open = ~global_mask;
    assign any_maskable  = req_ext_pin | req_chan_zero | req_chan_one
                         | req_overflow | req_keyboard | req_converter;

    // fixed priority selection
    wire src_t sel_src;
    assign sel_src =
        reset_request                    ? SRC_RESET     :
        software_interrupt_instruction   ? SRC_SOFT      :
        (maskable_open & req_ext_pin)    ? SRC_EXT_PIN   :
        (maskable_open & req_chan_zero)  ? SRC_CHAN_ZERO :
        (maskable_open & req_chan_one)   ? SRC_CHAN_ONE  :
        (maskable_open & req_overflow)   ? SRC_OVERFLOW  :
        (maskable_open & req_keyboard)   ? SRC_KEYBOARD  :
        (maskable_open & req_converter)  ? SRC_CONVERTER :
                                           SRC_NONE;

    // pc to be stacked for the selected source
    wire logic [15:0] sel_stack_pc;
    assign sel_stack_pc = (sel_src == SRC_SOFT) ? core_pc
                        : core_pc - HW_PC_ADJUST;

    wire logic take_now;
    assign take_now    = clk_en & instr_end & (sel_src != SRC_NONE);
    assign any_pending = reset_request | (maskable_open & any_maskable);

    // vector and stack hand-off to the core
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            take_valid  <= 1'b0;
            take_src    <= SRC_NONE;
            vector_addr <= RST_WORD;
            stacked_pc  <= RST_WORD;
        end else if (clk_en) begin
            take_valid <= take_now;
            if (take_now) begin
                take_src    <= sel_src;
                vector_addr <= vec_of(sel_src);
                stacked_pc  <= sel_stack_pc;
            end
        end
    end

    // read-only pending status images
    wire logic [7:0] next_status1;
    wire logic [7:0] next_status2;
    wire logic [7:0] next_status3;
    assign next_status1 = (8'(req_ext_pin)   << POS_STATUS_ONE)
                        | (8'(req_chan_zero) << POS_STATUS_THREE)
                        | (8'(req_chan_one)  << POS_STATUS_FOUR)
                        | (8'(req_overflow)  << POS_STATUS_FIVE);
    assign next_status2 = 8'(req_keyboard)  << POS_STATUS_FOURTEEN;
    assign next_status3 = 8'(req_converter) << POS_STATUS_FIFTEEN;

    logic [7:0] status1;
    logic [7:0] status2;
    logic [7:0] status3;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            status1 <= RST_BYTE;
            status2 <= RST_BYTE;
            status3 <= RST_BYTE;
        end else if (clk_en) begin
            status1 <= next_status1;
            status2 <= next_status2;
            status3 <= next_status3;
        end
    end

    // register decode
    wire logic wr_evt_stat;
    wire logic wr_evt_mask;
    assign wr_evt_stat = reg_wr & (reg_addr == OFS_EVT_STAT);
    assign wr_evt_mask = reg_wr & (reg_addr == OFS_EVT_MASK);

    // event status, set wins over write-one-clear
    logic [EVT_W-1:0] evt_stat;
    logic [EVT_W-1:0] evt_mask;
    wire logic [EVT_W-1:0] evt_set;
    wire logic [EVT_W-1:0] evt_clr;
    wire logic [EVT_W-1:0] next_evt_stat;
    assign evt_set[EVT_HW_TAKEN]   = take_now & (sel_src != SRC_SOFT)
                                   & (sel_src != SRC_RESET);
    assign evt_set[EVT_SOFT_TAKEN] = take_now & (sel_src == SRC_SOFT);
    assign evt_set[EVT_RST_TAKEN]  = take_now & (sel_src == SRC_RESET);
    assign evt_clr       = wr_evt_stat ? reg_wdata[EVT_W-1:0] : '0;
    assign next_evt_stat = (evt_stat & ~evt_clr) | evt_set;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            evt_stat <= '0;
            evt_mask <= '0;
        end else if (clk_en) begin
            evt_stat <= next_evt_stat;
            if (wr_evt_mask) begin
                evt_mask <= reg_wdata[EVT_W-1:0];
            end
        end
    end

    assign irq = |(evt_stat & evt_mask);

    // read mux, data one cycle after the strobe
    wire logic [7:0] rd_mux;
    assign rd_mux =
        (reg_addr == OFS_STATUS1)  ? status1 :
        (reg_addr == OFS_STATUS2)  ? status2 :
        (reg_addr == OFS_STATUS3)  ? status3 :
        (reg_addr == OFS_EVT_STAT) ? {{(8-EVT_W){1'b0}}, evt_stat} :
        (reg_addr == OFS_EVT_MASK) ? {{(8-EVT_W){1'b0}}, evt_mask} :
        (reg_addr == OFS_LAST_SRC) ? {4'h0, take_src} :
                                     RST_BYTE;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= RST_BYTE;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? rd_mux : RST_BYTE;
        end
    end

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_boundary;
        clk_en && instr_end && !reset_request;
    endsequence

    sequence s_soft_taken;
        take_valid && take_src == SRC_SOFT;
    endsequence

    sequence s_maskable_turn;
        s_boundary ##0 (!software_interrupt_instruction && !global_mask);
    endsequence

    a_soft_ignores_mask: assert property (
        s_boundary ##0 software_interrupt_instruction |=> s_soft_taken)
        else $error("software interrupt not taken");

    a_soft_stack_pc: assert property (
        s_boundary ##0 software_interrupt_instruction |=>
            stacked_pc == $past(core_pc))
        else $error("software interrupt stacked wrong pc");

    a_hw_stack_pc: assert property (
        s_boundary ##0 (!software_interrupt_instruction && !global_mask
            && any_maskable) |=> stacked_pc == $past(core_pc) - 16'h0001)
        else $error("hardware interrupt stacked wrong pc");

    a_mask_blocks: assert property (
        s_boundary ##0 (global_mask && !software_interrupt_instruction)
            |=> !take_valid)
        else $error("masked source was taken");

    a_chan_zero_rank: assert property (
        s_boundary ##0 (!software_interrupt_instruction && !global_mask
            && !req_ext_pin && req_chan_zero) |=> take_src == SRC_CHAN_ZERO)
        else $error("timer channel zero misranked");

    a_chan_one_rank: assert property (
        s_boundary ##0 (!software_interrupt_instruction && !global_mask
            && !req_ext_pin && !req_chan_zero && req_chan_one)
            |=> take_src == SRC_CHAN_ONE)
        else $error("timer channel one misranked");

    a_converter_last: assert property (
        s_boundary ##0 (!software_interrupt_instruction && !global_mask
            && req_converter && (req_ext_pin || req_chan_zero || req_chan_one
            || req_overflow || req_keyboard)) |=> take_src != SRC_CONVERTER)
        else $error("converter served ahead of higher source");

    a_status_mirror: assert property (
        clk_en |=> status1[POS_STATUS_THREE] == $past(req_chan_zero)
            && status1[POS_STATUS_FOUR] == $past(req_chan_one)
            && status3[POS_STATUS_FIFTEEN] == $past(req_converter))
        else $error("pending status does not follow request");

    a_ext_pin_first: assert property (
        s_boundary ##0 (!software_interrupt_instruction && !global_mask
            && req_ext_pin) |=> take_valid && take_src == SRC_EXT_PIN)
        else $error("pin request not serviced first");

    a_vector_pair: assert property (
        take_valid |-> !vector_addr[0]
            && (take_src != SRC_RESET     || vector_addr == VEC_RESET)
            && (take_src != SRC_SOFT      || vector_addr == VEC_SOFT)
            && (take_src != SRC_EXT_PIN   || vector_addr == VEC_EXT_PIN)
            && (take_src != SRC_CHAN_ZERO || vector_addr == VEC_CHAN_ZERO)
            && (take_src != SRC_CHAN_ONE  || vector_addr == VEC_CHAN_ONE)
            && (take_src != SRC_OVERFLOW  || vector_addr == VEC_OVERFLOW)
            && (take_src != SRC_KEYBOARD  || vector_addr == VEC_KEYBOARD)
            && (take_src != SRC_CONVERTER || vector_addr == VEC_CONVERTER))
        else $error("vector does not match source");

    a_reset_first: assert property (
        clk_en && instr_end && reset_request |=> take_valid && take_src == SRC_RESET)
        else $error("reset source not served first");

    a_overflow_rank: assert property (
        s_maskable_turn ##0 (!req_ext_pin && !req_chan_zero && !req_chan_one
            && req_overflow) |=> take_src == SRC_OVERFLOW)
        else $error("timer overflow misranked");

    a_keyboard_rank: assert property (
        s_maskable_turn ##0 (!req_ext_pin && !req_chan_zero && !req_chan_one
            && !req_overflow && req_keyboard) |=> take_src == SRC_KEYBOARD)
        else $error("keyboard request misranked");

    a_converter_taken: assert property (
        s_maskable_turn ##0 (req_converter && !(req_ext_pin || req_chan_zero
            || req_chan_one || req_overflow || req_keyboard))
            |=> take_valid && take_src == SRC_CONVERTER)
        else $error("lone converter request not taken");

    a_hw_event: assert property (
        s_maskable_turn ##0 any_maskable |=> evt_stat[EVT_HW_TAKEN])
        else $error("hardware take not recorded");

    a_soft_event: assert property (
        s_boundary ##0 software_interrupt_instruction |=> evt_stat[EVT_SOFT_TAKEN])
        else $error("software take not recorded");

    a_masked_no_event: assert property (
        s_boundary ##0 (global_mask && !software_interrupt_instruction)
            |=> !$rose(evt_stat[EVT_HW_TAKEN]))
        else $error("masked source recorded a take");

    a_pending_masked: assert property (
        global_mask && !reset_request |-> !any_pending)
        else $error("pending shown under global mask");

    a_idle_no_take: assert property (
        clk_en && !instr_end |=> !take_valid)
        else $error("take without instruction end");

    a_take_hold: assert property (
        clk_en && !instr_end |=> $stable(take_src) && $stable(vector_addr)
            && $stable(stacked_pc))
        else $error("vector outputs moved without a take");

    a_enable_freezes_state: assert property (
        !clk_en |=> $stable(take_valid) && $stable(take_src)
            && $stable(vector_addr) && $stable(stacked_pc)
            && $stable(status1) && $stable(status2) && $stable(status3)
            && $stable(evt_stat) && $stable(evt_mask) && $stable(reg_rdata))
        else $error("state moved while clock enable low");

    a_status_readout: assert property (
        clk_en && reg_rd && reg_addr == OFS_STATUS1 |=> reg_rdata == $past(status1))
        else $error("status read returned wrong byte");

    a_rdata_idle: assert property (
        clk_en && !reg_rd |=> reg_rdata == RST_BYTE)
        else $error("read data stands without a read");

    a_event_mask_write: assert property (
        clk_en && wr_evt_mask |=> evt_mask == $past(reg_wdata[EVT_W-1:0]))
        else $error("event mask write lost");

    a_event_clear: assert property (
        clk_en && wr_evt_stat && !take_now
            |=> (evt_stat & $past(reg_wdata[EVT_W-1:0])) == '0)
        else $error("event bit not cleared by write");

    a_status_map: assert property (
        clk_en |=> status1[POS_STATUS_ONE] == $past(req_ext_pin)
            && status1[POS_STATUS_FIVE] == $past(req_overflow)
            && status2[POS_STATUS_FOURTEEN] == $past(req_keyboard))
        else $error("status flag map wrong");

endmodule

// [shared/int_vec_pkg.sv]
// constants for interrupt priority and vectoring logic
package int_vec_pkg;

    // register map, 8-bit data
    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 8;
    localparam logic [3:0]  OFS_STATUS1   = 4'h0;
    localparam logic [3:0]  OFS_STATUS2   = 4'h1;
    localparam logic [3:0]  OFS_STATUS3   = 4'h2;
    localparam logic [3:0]  OFS_EVT_STAT  = 4'h3;
    localparam logic [3:0]  OFS_EVT_MASK  = 4'h4;
    localparam logic [3:0]  OFS_LAST_SRC  = 4'h5;

    // pending status bit positions
    localparam int          POS_STATUS_ONE      = 2;
    localparam int          POS_STATUS_THREE    = 4;
    localparam int          POS_STATUS_FOUR     = 5;
    localparam int          POS_STATUS_FIVE     = 6;
    localparam int          POS_STATUS_FOURTEEN = 7;
    localparam int          POS_STATUS_FIFTEEN  = 0;

    // event status bits
    localparam int          EVT_HW_TAKEN  = 0;
    localparam int          EVT_SOFT_TAKEN = 1;
    localparam int          EVT_RST_TAKEN = 2;
    localparam int          EVT_W         = 3;

    // reset values
    localparam logic [7:0]  RST_BYTE      = 8'h00;
    localparam logic [15:0] RST_WORD      = 16'h0000;

    // vector addresses (high byte address of each pair)
    localparam logic [15:0] VEC_RESET     = 16'hfffe;
    localparam logic [15:0] VEC_SOFT      = 16'hfffc;
    localparam logic [15:0] VEC_EXT_PIN   = 16'hfffa;
    localparam logic [15:0] VEC_CHAN_ZERO = 16'hfff6;
    localparam logic [15:0] VEC_CHAN_ONE  = 16'hfff4;
    localparam logic [15:0] VEC_OVERFLOW  = 16'hfff2;
    localparam logic [15:0] VEC_KEYBOARD  = 16'hffe0;
    localparam logic [15:0] VEC_CONVERTER = 16'hffde;

    // pc adjust for hardware interrupts
    localparam logic [15:0] HW_PC_ADJUST  = 16'h0001;

    // serviced source, highest priority first
    typedef enum logic [3:0] {
        SRC_NONE      = 4'b0000,
        SRC_RESET     = 4'b0001,
        SRC_SOFT      = 4'b0010,
        SRC_EXT_PIN   = 4'b0011,
        SRC_CHAN_ZERO = 4'b0100,
        SRC_CHAN_ONE  = 4'b0101,
        SRC_OVERFLOW  = 4'b0110,
        SRC_KEYBOARD  = 4'b0111,
        SRC_CONVERTER = 4'b1000
    } src_t;

endpackage

// [verif/core_model.sv]
// processor core model: instruction boundaries, noisy qualifiers between them
`timescale 1ns/1ns
module core_model (
    // clock and bench command
    input  wire logic        clk_sys,
    input  wire logic        step,
    input  wire logic        soft_step,
    input  wire logic [15:0] pc_step,
    // toward the arbiter
    output logic             instr_end,
    output logic             software_interrupt_instruction,
    output logic [15:0]      core_pc
);
    initial begin
        instr_end = 1'b0;
        software_interrupt_instruction = 1'b0;
        core_pc = 16'h0000;
    end
    // qualifiers only mean something beside instr_end, so scramble them otherwise
    always @(posedge clk_sys) begin
        instr_end <= step;
        software_interrupt_instruction <= step ? soft_step : ~software_interrupt_instruction;
        core_pc <= step ? pc_step : ~core_pc;
    end
endmodule

// [verif/int_vec_ctrl_tb_top.sv]
// random self-checking bench for the interrupt arbiter
`timescale 1ns/1ns
module int_vec_ctrl_tb_top
    import int_vec_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        clk_en = 1'b1;
    logic        reset_request = 1'b0;
    logic        global_mask = 1'b0;
    logic [5:0]  f = 6'h00;
    logic [5:0]  e = 6'h00;
    logic        step = 1'b0;
    logic        soft_step = 1'b0;
    logic [15:0] pc_step = 16'h0000;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        instr_end;
    logic        software_interrupt_instruction;
    logic        any_pending;
    logic        take_valid;
    logic        irq;
    logic [15:0] core_pc;
    logic [15:0] vector_addr;
    logic [15:0] stacked_pc;
    logic [7:0]  reg_rdata;
    src_t        take_src;
    int          bad_count = 0;
    int          comparisons = 0;
    int          cycles = 0;
    // corner cases: flags, enables, global mask, swi, reset
    logic [14:0] corner [4] = '{{6'h3f, 6'h3f, 3'b100}, {6'h3f, 6'h3f, 3'b110},
                                {6'h06, 6'h3f, 3'b000}, {6'h20, 6'h3f, 3'b000}};

    core_model core (.clk_sys, .step, .soft_step, .pc_step, .instr_end,
                     .software_interrupt_instruction, .core_pc);
    int_vec_ctrl uut (.clk_sys, .rst_n, .clk_en, .reset_request,
        .ext_pin_request_flag(f[0]), .ext_pin_request_mask(~e[0]),
        .timer_chan_zero_flag(f[1]), .timer_chan_zero_enable(e[1]),
        .timer_chan_one_flag(f[2]), .timer_chan_one_enable(e[2]),
        .timer_overflow_flag(f[3]), .timer_overflow_enable(e[3]),
        .keyboard_request_flag(f[4]), .keyboard_request_mask(~e[4]),
        .conversion_done_flag(f[5]), .converter_request_enable(e[5]),
        .instr_end, .software_interrupt_instruction, .global_mask, .core_pc,
        .any_pending, .take_valid, .take_src, .vector_addr, .stacked_pc,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);

    always #2 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 12000) begin
            bad_count++;
            complete_run();
        end
    end

    function automatic src_t pick(input logic [5:0] rq, input logic rs, sw, gm);
        if (rs) return SRC_RESET;
        if (sw) return SRC_SOFT;
        for (int i = 0; i < 6; i++) if (!gm && rq[i]) return src_t'(4'(3 + i));
        return SRC_NONE;
    endfunction

    function automatic logic [15:0] vec(input src_t s);
        case (s)
            SRC_RESET:     return VEC_RESET;
            SRC_SOFT:      return VEC_SOFT;
            SRC_EXT_PIN:   return VEC_EXT_PIN;
            SRC_CHAN_ZERO: return VEC_CHAN_ZERO;
            SRC_CHAN_ONE:  return VEC_CHAN_ONE;
            SRC_OVERFLOW:  return VEC_OVERFLOW;
            SRC_KEYBOARD:  return VEC_KEYBOARD;
            default:       return VEC_CONVERTER;
        endcase
    endfunction

    function automatic logic [23:0] stat(input logic [5:0] rq);
        logic [7:0] s [3];
        s = '{8'h00, 8'h00, 8'h00};
        s[0][POS_STATUS_ONE] = rq[0];
        s[0][POS_STATUS_THREE] = rq[1];
        s[0][POS_STATUS_FOUR] = rq[2];
        s[0][POS_STATUS_FIVE] = rq[3];
        s[1][POS_STATUS_FOURTEEN] = rq[4];
        s[2][POS_STATUS_FIFTEEN] = rq[5];
        return {s[2], s[1], s[0]};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic complete_run();
        if (bad_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        logic [7:0]  d;
        logic [5:0]  fv, ev, rq;
        logic        gm, sw, rs, ce;
        logic [2:0]  evt, msk;
        logic [15:0] pc, last_vec, last_pc;
        logic [23:0] st;
        src_t        ex, last_src;
        void'($urandom(72));
        {last_src, last_vec, last_pc, evt} = '0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int n = 0; n < 300; n++) begin
            msk = 3'($urandom);
            wr(OFS_EVT_MASK, {5'h00, msk});
            {fv, ev, gm, sw, rs} = {6'($urandom), 6'($urandom), 2'($urandom), ($urandom % 8) == 0};
            if (n < 4) {fv, ev, gm, sw, rs} = corner[n];
            ce = (n < 4) || ($urandom % 4) != 0;
            rq = fv & ev;
            pc = 16'($urandom);
            @(posedge clk_sys);
            f <= fv;
            e <= ev;
            global_mask <= gm;
            reset_request <= rs;
            @(posedge clk_sys);
            step <= 1'b1;
            soft_step <= sw;
            pc_step <= pc;
            @(posedge clk_sys);
            step <= 1'b0;
            clk_en <= ce;
            @(posedge clk_sys);
            clk_en <= 1'b1;
            #1 ex = ce ? pick(rq, rs, sw, gm) : SRC_NONE;
            if (ex != SRC_NONE) begin
                last_src = ex;
                last_vec = vec(ex);
                last_pc = (ex == SRC_SOFT) ? pc : pc - 16'h0001;
                evt[(ex == SRC_RESET) ? EVT_RST_TAKEN : (ex == SRC_SOFT) ? EVT_SOFT_TAKEN
                    : EVT_HW_TAKEN] = 1'b1;
            end
            chk(any_pending, rs | (~gm & |rq));
            chk(take_valid, ex != SRC_NONE);
            chk(take_src, last_src);
            chk(vector_addr, last_vec);
            chk(stacked_pc, last_pc);
            chk(irq, |(evt & msk));
            @(posedge clk_sys);
            #1 chk(take_valid, 1'b0);
            wr(OFS_STATUS1, 8'hff);
            st = stat(rq);
            for (int i = 0; i < 3; i++) begin
                rd(OFS_STATUS1 + 4'(i), d);
                chk(d, st[8*i +: 8]);
            end
            rd(OFS_EVT_STAT, d);
            chk(d, evt);
            rd(OFS_EVT_MASK, d);
            chk(d, msk);
            rd(OFS_LAST_SRC, d);
            chk(d, last_src);
            rd(4'hf, d);
            chk(d, 8'h00);
            wr(OFS_EVT_STAT, {5'h00, evt});
            evt = 3'h0;
            #1 chk(irq, 1'b0);
        end
        complete_run();
    end
endmodule
